//--- swr_slave.sv
// Single-wire ID-command slave with resolution config, CRCs and alarm
// How it works
// - Config bits 6 and 5 pick 9, 10, 11 or 12-bit resolution.
// - Both resolution bits come up as one: 12-bit default.
// - Config bit 7 stays zero, bits 4..0 stay one; writes ignored there.
// - Conversion ends within 93.75, 187.5, 375 or 750 ms by resolution.
// - CRC x^8+x^5+x^4+1, cleared register, LSB first one bit each.
// - ID top byte is CRC of 56 bits; scratchpad byte 8 is CRC.
// - Scratchpad CRC follows every change of scratchpad contents.
// - A CRC mismatch never blocks or aborts any command sequence.
// - All command and data bits travel least significant bit first.
// - Line driven only open-drain, released whenever not transmitting.
// - Line low over 480 us is a bus reset to the initial state.
// - Unlimited recovery between bits while the line stays high.
// - Transaction opens with reset pulse, answered by a presence pulse.
// - Only reset, ID command, function command order is obeyed.
// - Five 8-bit ID commands, taken after presence, before function command.
// - F0h joins the bitwise elimination search.
// - 33h sends the whole 64-bit identifier.
// - 55h compares next 64 bits; match selects, else wait for reset.
// - CCh selects without any identifier.
// - ECh acts as search only while alarm flag is set.
// - Alarm set when temp bits 11..4 <= low or >= high threshold.
// - After reset rise wait 15-60 us, then drive low 60-240 us.
`timescale 1ns/10ps
`default_nettype none
module swr_slave #(
    parameter logic [7:0] FAMILY_CODE = 8'h5a,    // Arbitrary value
    parameter logic [47:0] SERIAL = 48'h0123_4567_89ab, // Arbitrary value
    parameter int US_CYC = `SWR_CLK_MHZ, // Clock cycles per microsecond
    parameter int CONV_CYC = `SWR_CYC(`SWR_T_CONV_US)
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic dq_in,
    output logic dq_out,
    output logic dq_oe_n,
    input wire swr_pkg::swr_sp_wr_s sp_wr,
    input wire logic conv_start,
    input wire logic [15:0] temp_in,
    output logic [7:0] resolution_config,
    output logic [7:0] sp_crc,
    output logic alarm,
    output logic conv_busy,
    output logic conv_done,
    output logic [7:0] func_cmd,
    output logic func_valid
);
    ////////////////////////////////////////////////////////////////////////
    // Bus timing scales with US_CYC, so a bench may run short slots
    localparam logic [15:0] T_RST = 16'(`SWR_T_RST_US * US_CYC);
    localparam logic [15:0] T_PDLY = 16'(`SWR_T_PDLY_US * US_CYC);
    localparam logic [15:0] T_PLOW = 16'(`SWR_T_PLOW_US * US_CYC);
    localparam logic [15:0] T_SAMP = 16'(`SWR_T_SAMP_US * US_CYC);
    localparam logic [15:0] T_TX = 16'(`SWR_T_TX_US * US_CYC);
    localparam logic [26:0] CONV_FULL = 27'(CONV_CYC);
    localparam logic [55:0] ROM_LOW = {SERIAL, FAMILY_CODE};
    localparam logic [63:0] ROM = {swr_pkg::swr_crc8({8'h00, ROM_LOW}, 56), ROM_LOW};

    logic [1:0] rst_q;
    logic rst_n;
    swr_pkg::swr_regs_s r, n;
    logic [63:0] sp_low;
    logic [1:0] res;
    logic [26:0] conv_lim;
    logic fall, rise, evt, rom_bit, tx_bit, tx_en;

    // Two-flop release so every state flop leaves reset on one edge
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    ////////////////////////////////////////////////////////////////////////
    assign sp_low = {`SWR_SP7, `SWR_SP6, `SWR_SP5, r.cfg, r.tl, r.th, r.temp};
    assign res = {r.cfg[`SWR_CFG_RES_HI], r.cfg[`SWR_CFG_RES_LO]};
    assign conv_lim = CONV_FULL >> (2'd3 - res);
    assign fall = r.dq_prev & ~dq_in;
    assign rise = ~r.dq_prev & dq_in;
    assign evt = r.slot && (r.tim == T_SAMP);
    assign rom_bit = ROM[r.bitn];
    // Only reads of the ID and the first two search phases transmit
    assign tx_en = (r.st == swr_pkg::SWR_READ) ||
                   (r.st == swr_pkg::SWR_SEARCH && r.phase != 2'd2);
    assign tx_bit = (r.st == swr_pkg::SWR_SEARCH && r.phase == 2'd1) ? ~rom_bit : rom_bit;

    // One copy of the state is worked out here and registered below
    always_comb begin
        n = r;
        n.func_valid = 1'b0;
        n.conv_done = 1'b0;
        n.dq_prev = dq_in;
        n.sp_crc = swr_pkg::swr_crc8(sp_low, 64);
        n.low_cnt = dq_in ? 16'h0000 : ((r.low_cnt == 16'hffff) ? r.low_cnt : r.low_cnt + 16'h1);

        // Scratchpad writes from the function-command layer
        if (sp_wr.valid) begin
            n.th = sp_wr.th;
            n.tl = sp_wr.tl;
            n.cfg = (sp_wr.cfg & 8'h60) | `SWR_CFG_FIXED;
        end

        // Conversion timer; result lands no later than the resolution limit
        if (conv_start && !r.conv_busy) begin
            n.conv_busy = 1'b1;
            n.conv_cnt = 27'h0;
        end else if (r.conv_busy) begin
            n.conv_cnt = r.conv_cnt + 27'h1;
            if (r.conv_cnt + 27'h1 >= conv_lim) begin
                n.conv_busy = 1'b0;
                n.conv_done = 1'b1;
                n.temp = temp_in;
                n.alarm = ($signed(temp_in[11:4]) <= $signed(r.tl)) ||
                          ($signed(temp_in[11:4]) >= $signed(r.th));
            end
        end

        // Slot timing: count from each falling edge the master makes
        if (r.slot) begin
            n.tim = r.tim + 16'h1;
            if (r.tim == T_TX) begin
                n.oe_n = 1'b1;
            end
            if (r.tim == T_SAMP) begin
                n.slot = 1'b0;
            end
        end else if (fall && r.oe_n && r.st != swr_pkg::SWR_PWAIT &&
                     r.st != swr_pkg::SWR_PDRV) begin
            n.slot = 1'b1;
            n.tim = 16'h1;
            if (tx_en && !tx_bit) begin
                n.oe_n = 1'b0;
            end
        end

        // Bit handling on the sample point of each slot
        unique case (r.st)
            swr_pkg::SWR_IDLE, swr_pkg::SWR_DONE: ;
            swr_pkg::SWR_PWAIT: begin
                if (rise) begin
                    n.tim = 16'h0;
                    n.st = swr_pkg::SWR_PDRV;
                end
            end
            swr_pkg::SWR_PDRV: begin
                n.tim = r.tim + 16'h1;
                if (r.tim == T_PDLY) begin
                    n.oe_n = 1'b0;
                end else if (r.tim == T_PDLY + T_PLOW) begin
                    n.oe_n = 1'b1;
                    n.tim = 16'h0;
                    n.st = swr_pkg::SWR_ROMCMD;
                end
            end
            swr_pkg::SWR_ROMCMD, swr_pkg::SWR_FUNC: begin
                if (evt) begin
                    n.shreg = {dq_in, r.shreg[7:1]};
                    n.bitn = r.bitn + 6'h1;
                    if (r.bitn == 6'd7) begin
                        n.bitn = 6'h0;
                        n.phase = 2'd0;
                        n.match_ok = 1'b1;
                        n.st = swr_pkg::SWR_DONE;
                        if (r.st == swr_pkg::SWR_FUNC) begin
                            n.func_cmd = {dq_in, r.shreg[7:1]};
                            n.func_valid = 1'b1;
                        end else begin
                            unique case ({dq_in, r.shreg[7:1]})
                                `SWR_CMD_SEARCH: n.st = swr_pkg::SWR_SEARCH;
                                `SWR_CMD_READ: n.st = swr_pkg::SWR_READ;
                                `SWR_CMD_MATCH: n.st = swr_pkg::SWR_MATCH;
                                `SWR_CMD_SKIP: n.st = swr_pkg::SWR_FUNC;
                                `SWR_CMD_ALARM: begin
                                    if (r.alarm) begin
                                        n.st = swr_pkg::SWR_SEARCH;
                                    end
                                end
                                default: n.st = swr_pkg::SWR_DONE;
                            endcase
                        end
                    end
                end
            end
            swr_pkg::SWR_READ: begin
                if (evt) begin
                    n.bitn = r.bitn + 6'h1;
                    if (r.bitn == 6'd63) begin
                        n.st = swr_pkg::SWR_FUNC;
                    end
                end
            end
            swr_pkg::SWR_MATCH: begin
                if (evt) begin
                    n.bitn = r.bitn + 6'h1;
                    if (dq_in != rom_bit) begin
                        n.match_ok = 1'b0;
                    end
                    if (r.bitn == 6'd63) begin
                        n.st = (r.match_ok && dq_in == rom_bit) ? swr_pkg::SWR_FUNC
                                                                 : swr_pkg::SWR_DONE;
                    end
                end
            end
            swr_pkg::SWR_SEARCH: begin
                if (evt) begin
                    n.phase = r.phase + 2'd1;
                    if (r.phase == 2'd2) begin
                        n.phase = 2'd0;
                        n.bitn = r.bitn + 6'h1;
                        // Losers stay off the line until the master resets
                        if (dq_in != rom_bit || r.bitn == 6'd63) begin
                            n.st = swr_pkg::SWR_DONE;
                        end
                    end
                end
            end
            default: n.st = swr_pkg::SWR_IDLE;
        endcase

        // A long low wins over everything and drops all partial progress;
        // the line going high ends it, so the rise into presence is kept
        if (r.low_cnt >= T_RST && r.oe_n && !dq_in) begin
            n.st = swr_pkg::SWR_PWAIT;
            n.slot = 1'b0;
            n.bitn = 6'h0;
            n.phase = 2'd0;
            n.shreg = 8'h00;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '{st: swr_pkg::SWR_IDLE, dq_prev: 1'b1, oe_n: 1'b1, slot: 1'b0,
                   low_cnt: 16'h0, tim: 16'h0, bitn: 6'h0, phase: 2'd0, match_ok: 1'b1,
                   shreg: 8'h00, func_cmd: 8'h00, func_valid: 1'b0,
                   cfg: `SWR_CFG_RST, th: `SWR_TH_RST, tl: `SWR_TL_RST,
                   temp: `SWR_TEMP_RST, alarm: 1'b0, conv_busy: 1'b0, conv_done: 1'b0,
                   conv_cnt: 27'h0, sp_crc: 8'h00};
        end else begin
            r <= n;
        end
    end

    assign dq_out = 1'b0;
    assign dq_oe_n = r.oe_n;
    assign resolution_config = r.cfg;
    assign sp_crc = r.sp_crc;
    assign alarm = r.alarm;
    assign conv_busy = r.conv_busy;
    assign conv_done = r.conv_done;
    assign func_cmd = r.func_cmd;
    assign func_valid = r.func_valid;

    ////////////////////////////////////////////////////////////////////////
    // Checks on the state register, gathered here at the end of the module
    a_cfg_fixed_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
        r.cfg[7] == 1'b0 && r.cfg[4:0] == 5'h1f) else $error("config fixed bits altered");
    a_crc_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $changed(sp_low) |=> r.sp_crc == swr_pkg::swr_crc8($past(sp_low), 64))
        else $error("scratchpad CRC stale");
    a_conv_bound: assert property (@(posedge ref_clk) disable iff (!rst_n)
        r.conv_busy |-> r.conv_cnt < conv_lim) else $error("conversion overran limit");
    a_reset_detect: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (r.low_cnt >= T_RST && r.oe_n && !dq_in) |=> r.st == swr_pkg::SWR_PWAIT && !r.slot)
        else $error("long low not taken as reset");

    a_line_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!r.slot && r.st != swr_pkg::SWR_PDRV) |-> r.oe_n)
        else $error("line held outside a slot");
    a_pres_width: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (r.st == swr_pkg::SWR_PDRV && !r.oe_n) |-> r.tim > T_PDLY && r.tim <= T_PDLY + T_PLOW)
        else $error("presence pulse out of window");
    a_func_source: assert property (@(posedge ref_clk) disable iff (!rst_n)
        r.func_valid |-> $past(r.st) == swr_pkg::SWR_FUNC)
        else $error("function byte out of order");
    a_skip_select: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (r.st == swr_pkg::SWR_ROMCMD && evt && r.bitn == 6'd7 && r.low_cnt < T_RST &&
         {dq_in, r.shreg[7:1]} == `SWR_CMD_SKIP) |=> r.st == swr_pkg::SWR_FUNC)
        else $error("broadcast selection not taken");
    a_read_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (r.st == swr_pkg::SWR_READ && !r.oe_n) |-> !rom_bit) else $error("ID bit sent wrong");

    a_pres_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (r.st == swr_pkg::SWR_PWAIT) |-> r.oe_n) else $error("drive before reset rise");
    a_search_drop: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (r.st == swr_pkg::SWR_SEARCH && evt && r.phase == 2'd2 && dq_in != rom_bit &&
         r.low_cnt < T_RST) |=> r.st == swr_pkg::SWR_DONE) else $error("search loser kept on");
    a_match_fail: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (r.st == swr_pkg::SWR_MATCH && evt && dq_in != rom_bit && r.low_cnt < T_RST)
        |=> !r.match_ok) else $error("ID mismatch not recorded");
    a_alarm_silent: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (r.st == swr_pkg::SWR_ROMCMD && evt && r.bitn == 6'd7 && !r.alarm &&
         {dq_in, r.shreg[7:1]} == `SWR_CMD_ALARM && r.low_cnt < T_RST)
        |=> r.st == swr_pkg::SWR_DONE) else $error("alarm search answered without alarm");
    a_lsb_first: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (r.st == swr_pkg::SWR_ROMCMD && evt && r.low_cnt < T_RST)
        |=> r.shreg[7] == $past(dq_in)) else $error("bit order wrong");
endmodule // swr_slave
`default_nettype wire

//--- swr_defines.svh
// Constants for the single-wire ID-command slave
`ifndef SWR_DEFINES_SVH
`define SWR_DEFINES_SVH

`define SWR_CLK_MHZ 100
`define SWR_T_RST_US 480
`define SWR_T_PDLY_US 30
`define SWR_T_PLOW_US 120
`define SWR_T_SAMP_US 30
`define SWR_T_TX_US 30
`define SWR_T_CONV_US 750000
`define SWR_CYC(us) ((us) * `SWR_CLK_MHZ)

`define SWR_CMD_SEARCH 8'hf0
`define SWR_CMD_READ 8'h33
`define SWR_CMD_MATCH 8'h55
`define SWR_CMD_SKIP 8'hcc
`define SWR_CMD_ALARM 8'hec

`define SWR_CFG_OFS 4'h4
`define SWR_CFG_RST 8'h7f
`define SWR_CFG_RES_HI 6
`define SWR_CFG_RES_LO 5
`define SWR_CFG_FIXED 8'h1f
`define SWR_TEMP_RST 16'h0550
`define SWR_TH_RST 8'h4b
`define SWR_TL_RST 8'h46
`define SWR_SP5 8'hff
`define SWR_SP6 8'h00
`define SWR_SP7 8'h10
`define SWR_CRC_POLY 8'h8c

`endif

//--- swr_pkg.sv
// Types and the CRC function of the single-wire ID-command slave
`default_nettype none
`include "swr_defines.svh"
package swr_pkg;
    typedef enum logic [3:0] {
        SWR_IDLE = 4'h0,
        SWR_PWAIT = 4'h1,
        SWR_PDRV = 4'h3,
        SWR_ROMCMD = 4'h2,
        SWR_FUNC = 4'h6,
        SWR_DONE = 4'h7,
        SWR_READ = 4'h5,
        SWR_MATCH = 4'h4,
        SWR_SEARCH = 4'hc
    } swr_state_e;

    typedef struct packed {
        logic valid;
        logic [7:0] cfg;
        logic [7:0] tl;
        logic [7:0] th;
    } swr_sp_wr_s;

    typedef struct packed {
        swr_state_e st;
        logic dq_prev;
        logic oe_n;
        logic slot;
        logic [15:0] low_cnt;
        logic [15:0] tim;
        logic [5:0] bitn;
        logic [1:0] phase;
        logic match_ok;
        logic [7:0] shreg;
        logic [7:0] func_cmd;
        logic func_valid;
        logic [7:0] cfg;
        logic [7:0] th;
        logic [7:0] tl;
        logic [15:0] temp;
        logic alarm;
        logic conv_busy;
        logic conv_done;
        logic [26:0] conv_cnt;
        logic [7:0] sp_crc;
    } swr_regs_s;

    // Shift n bits in, LSB first, from a cleared register
    function automatic logic [7:0] swr_crc8(input logic [63:0] d, input int n);
        logic [7:0] c;
        logic fb;
        c = 8'h00;
        for (int i = 0; i < 64; i++) begin
            if (i < n) begin
                fb = c[0] ^ d[i];
                c = {1'b0, c[7:1]} ^ (fb ? `SWR_CRC_POLY : 8'h00);
            end
        end
        return c;
    endfunction
endpackage
`default_nettype wire

//--- swr_master_model.sv
// Bus master model that drives the open-drain line of the slave
`timescale 1ns/10ps
`default_nettype none
module swr_master_model #(
    parameter int US = 100
) (
    input wire logic ref_clk,
    input wire logic dq,
    output var logic mst_oe_n
);
    initial mst_oe_n = 1'b1;

    // Low past the reset limit, then look for presence in its window
    task automatic bus_reset(output logic pres);
        logic early;
        @(posedge ref_clk);
        #1 mst_oe_n = 1'b0;
        repeat (485 * US) @(posedge ref_clk);
        #1 mst_oe_n = 1'b1;
        repeat (10 * US) @(posedge ref_clk);
        #1 early = dq;
        repeat (35 * US) @(posedge ref_clk);
        #1 pres = early & ~dq;
        repeat (120 * US) @(posedge ref_clk);
    endtask

    // A 1 or read slot is a short low; a 0 holds low past the sample point
    task automatic slot(input logic b, output logic r);
        @(posedge ref_clk);
        #1 mst_oe_n = 1'b0;
        repeat (b ? US : 31 * US) @(posedge ref_clk);
        #1 mst_oe_n = 1'b1;
        repeat (b ? 9 * US : 1) @(posedge ref_clk);
        #1 r = dq;
        repeat (b ? 22 * US : US - 1) @(posedge ref_clk);
    endtask

    task automatic send_bits(input logic [63:0] v, input int n);
        logic r;
        for (int i = 0; i < n; i++) slot(v[i], r);
    endtask

    task automatic read_bits(input int n, output logic [63:0] v);
        v = '0;
        for (int i = 0; i < n; i++) slot(1'b1, v[i]);
    endtask
endmodule // swr_master_model
`default_nettype wire

//--- single_wire_rom_command_slave_test.sv
// Self-checking bench for the single-wire ID-command slave
`timescale 1ns/10ps
`default_nettype none
module single_wire_rom_command_slave_test;
    localparam logic [7:0] FAM = 8'h3c; // Arbitrary value
    localparam logic [47:0] SER = 48'h1a2b_3c4d_5e6f; // Arbitrary value
    localparam int CONV = 800;
    localparam int US = 2; // Short microseconds keep the run brief; ratios unchanged
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic conv_start = 1'b0;
    logic [15:0] temp_in = 16'h0000;
    swr_pkg::swr_sp_wr_s sp_wr = '0;
    logic dq_out, dq_oe_n, mst_oe_n, alarm, conv_busy, conv_done, func_valid, p;
    int fv_cnt = 0;
    logic [7:0] resolution_config, sp_crc, func_cmd, fv_cmd, th_m, tl_m, cfg_m;
    logic [15:0] temp_m;
    logic [63:0] id, rd;
    int err_count = 0;
    int cmp_count = 0;
    // Pull-up wins unless some party pulls low
    wire logic dq = mst_oe_n & (dq_oe_n | dq_out);

    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (func_valid === 1'b1) begin
        fv_cnt <= fv_cnt + 1;
        fv_cmd <= func_cmd;
    end

    swr_slave #(.FAMILY_CODE(FAM), .SERIAL(SER), .US_CYC(US), .CONV_CYC(CONV)) DUT (
        .ref_clk(ref_clk), .reset_n(reset_n), .dq_in(dq), .dq_out(dq_out),
        .dq_oe_n(dq_oe_n), .sp_wr(sp_wr), .conv_start(conv_start), .temp_in(temp_in),
        .resolution_config(resolution_config), .sp_crc(sp_crc), .alarm(alarm),
        .conv_busy(conv_busy), .conv_done(conv_done), .func_cmd(func_cmd),
        .func_valid(func_valid));
    swr_master_model #(.US(US)) M (.ref_clk(ref_clk), .dq(dq), .mst_oe_n(mst_oe_n));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] crc_of(input logic [63:0] d, input int n);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < n; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8c : 8'h00);
        return c;
    endfunction

    function automatic logic [7:0] sp_exp();
        return crc_of({8'h10, 8'h00, 8'hff, cfg_m, tl_m, th_m, temp_m}, 64);
    endfunction

    // Threshold compare is two's complement on the integer part
    function automatic logic alarm_of(input logic [15:0] t);
        return $signed(t[11:4]) <= $signed(tl_m) || $signed(t[11:4]) >= $signed(th_m);
    endfunction

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic wr_cfg(input logic [7:0] c, input logic [7:0] h, input logic [7:0] l);
        @(posedge ref_clk);
        #1 sp_wr = '{valid: 1'b1, cfg: c, tl: l, th: h};
        @(posedge ref_clk);
        #1 sp_wr.valid = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 cfg_m = {1'b0, c[6:5], 5'h1f};
        th_m = h;
        tl_m = l;
        check(resolution_config, cfg_m);
        check(sp_crc, sp_exp());
    endtask

    task automatic convert(input logic [15:0] t);
        int n;
        int lim;
        n = 0;
        lim = CONV >> (3 - cfg_m[6:5]);
        @(posedge ref_clk);
        #1 temp_in = t;
        conv_start = 1'b1;
        @(posedge ref_clk);
        #1 conv_start = 1'b0;
        while (conv_done !== 1'b1 && n < 20000) begin
            @(posedge ref_clk);
            #1 n++;
        end
        check(n + 4 >= lim && n <= lim + 4, 1'b1);
        repeat (2) @(posedge ref_clk);
        #1 temp_m = t;
        check(alarm, alarm_of(t));
        check(sp_crc, sp_exp());
    endtask

    task automatic txn(input logic [7:0] cmd);
        logic pr;
        M.bus_reset(pr);
        check(pr, 1'b1);
        M.send_bits({56'h0, cmd}, 8);
    endtask

    task automatic func_chk(input logic take);
        logic [7:0] f;
        int c0;
        f = 8'($urandom);
        c0 = fv_cnt;
        M.send_bits({56'h0, f}, 8);
        repeat (5) @(posedge ref_clk);
        check(64'(fv_cnt - c0), 64'(take));
        if (take) check(fv_cmd, f);
    endtask

    // Follows the device for eight bits, then picks the other branch on the ninth
    task automatic search_chk(input logic act);
        logic a, b;
        for (int i = 0; i < 10; i++) begin
            M.slot(1'b1, a);
            M.slot(1'b1, b);
            check({a, b}, (act && i < 9) ? {id[i], ~id[i]} : 2'b11);
            M.slot(i == 8 ? ~id[i] : id[i], a);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hf4ae));
        id = {crc_of({8'h00, SER, FAM}, 56), SER, FAM};
        temp_m = 16'h0550;
        th_m = 8'h4b;
        tl_m = 8'h46;
        cfg_m = 8'h7f;
        repeat (10) @(posedge ref_clk);
        #1 reset_n = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 check(resolution_config, 8'h7f);
        check(sp_crc, sp_exp());
        check(dq_oe_n, 1'b1);
        $display("test reset done");
        for (int r = 0; r < 4; r++) begin
            wr_cfg(8'($urandom) & 8'h9f | 8'(r << 5), 8'($urandom), 8'($urandom));
            convert(16'($urandom));
        end
        $display("test config done");
        txn(8'h33);
        M.read_bits(64, rd);
        check(rd, id);
        check(crc_of(rd, 64), 8'h00);
        func_chk(1'b1);
        txn(8'hcc);
        repeat (5000) @(posedge ref_clk);
        func_chk(1'b1);
        txn(8'h55);
        M.send_bits(id, 64);
        func_chk(1'b1);
        txn(8'h55);
        M.send_bits(id ^ (64'h1 << ($urandom % 64)), 64);
        func_chk(1'b0);
        txn(8'h0f);
        func_chk(1'b0);
        $display("test select done");
        M.bus_reset(p);
        check(p, 1'b1);
        M.send_bits(64'h55, 4);
        txn(8'hcc);
        func_chk(1'b1);
        txn(8'hf0);
        search_chk(1'b1);
        wr_cfg(8'h7f, 8'h7f, 8'h80);
        convert(16'h0000);
        txn(8'hec);
        search_chk(1'b0);
        wr_cfg(8'h7f, 8'h80, 8'h80);
        convert(16'h0000);
        txn(8'hec);
        search_chk(1'b1);
        $display("test search done");
        conclude();
    end

    // Bus traffic needs about half a millisecond at this time scale
    initial begin
        #1_000_000;
        err_count++;
        conclude();
    end
endmodule // single_wire_rom_command_slave_test
`default_nettype wire
